/* logic/pmic_power_control_inputs.sv */
// power-on and standby input qualification with apb control registers
`timescale 1ns/1ns
`default_nettype none
module pmic_power_control_inputs #(
  parameter int unsigned DBNC_SHORT = pwr_ctrl_pkg::DBNC_SHORT_CYC,
  parameter int unsigned DBNC_MID   = pwr_ctrl_pkg::DBNC_MID_CYC,
  parameter int unsigned DBNC_LONG  = pwr_ctrl_pkg::DBNC_LONG_CYC,
  parameter int unsigned LONG_PRESS = pwr_ctrl_pkg::LONG_PRESS_CYC,
  parameter int unsigned HOLD_SHORT = pwr_ctrl_pkg::HOLD_SHORT_CYC,
  parameter int unsigned HOLD_MID   = pwr_ctrl_pkg::HOLD_MID_CYC,
  parameter int unsigned HOLD_LONG  = pwr_ctrl_pkg::HOLD_LONG_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        powerOnPin,
  input  wire logic        standbyPin,
  input  wire logic        powerInputSenseSelect,
  input  wire logic        sleepOnTurnOff,
  output logic [1:0]       powerState,
  output logic             standbyActive,
  output logic             powerOnIrq
);

  localparam int CW = pwr_ctrl_pkg::CNT_W;

  // register file state
  logic [5:0]  ctrl_r;
  logic [5:0]  ctrl_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        senseEdge_r;
  logic        senseEdge_nxt;

  // power state
  pwr_ctrl_pkg::pwr_state_e state_r;
  pwr_ctrl_pkg::pwr_state_e state_nxt;
  pwr_ctrl_pkg::pwr_state_e offTarget;
  logic        irq_r;
  logic        irq_nxt;
  logic [CW-1:0] longCnt_r;
  logic [CW-1:0] longCnt_nxt;
  logic        longDone_r;
  logic        longDone_nxt;
  logic        longFire;
  logic        levelOk_r;
  logic        levelOk_nxt;
  logic [1:0]  settle_r;
  logic [1:0]  settle_nxt;

  // standby path
  logic        stbyMeta_r;
  logic        stbySync_r;
  logic        stbyApplied_r;
  logic        stbyApplied_nxt;
  logic [CW-1:0] holdCnt_r;
  logic [CW-1:0] holdCnt_nxt;
  logic [CW-1:0] holdCycles;
  logic        stbyReq;

  // qualifier outputs and fall window
  logic        onSync;
  logic        onLevel;
  logic        onRose;
  logic        onFell;
  logic [CW-1:0] fallCycles;

  // bus and state decode
  logic        access;
  logic        wrStrobe;
  logic        isOff;
  logic        isAsleep;
  logic        isAwake;

  function automatic logic addrHit(input logic [11:0] a);
    addrHit = (a == pwr_ctrl_pkg::CTRL_OFS) ||
              (a == pwr_ctrl_pkg::STATUS_OFS) ||
              (a == pwr_ctrl_pkg::INT_OFS);
  endfunction

  function automatic logic [CW-1:0] dbncCycles(input logic [1:0] sel);
    unique case (sel)
      2'h2:    dbncCycles = CW'(DBNC_MID);
      2'h3:    dbncCycles = CW'(DBNC_LONG);
      default: dbncCycles = CW'(DBNC_SHORT);
    endcase
  endfunction

  function automatic logic [CW-1:0] holdOff(input logic [1:0] sel);
    unique case (sel)
      2'h1:    holdOff = CW'(HOLD_SHORT);
      2'h2:    holdOff = CW'(HOLD_MID);
      2'h3:    holdOff = CW'(HOLD_LONG);
      default: holdOff = '0;
    endcase
  endfunction

  // fall time follows the select, rise time never does
  assign fallCycles = dbncCycles(
    ctrl_r[pwr_ctrl_pkg::CTRL_DBNC_LSB +: 2]);

  pwr_input_qualifier #(
    .CW (CW)
  ) u_qual (
    .mclk       (mclk),
    .rst        (rst),
    .pinAsync   (powerOnPin),
    .fallCycles (fallCycles),
    .riseCycles (CW'(DBNC_SHORT)),
    .syncLevel  (onSync),
    .level      (onLevel),
    .rosePulse  (onRose),
    .fellPulse  (onFell)
  );

  // ---------------- apb slave ----------------
  assign access   = psel & penable;
  assign wrStrobe = access & pwrite;
  assign pready   = 1'b1;
  assign pslverr  = access & ~addrHit(paddr);

  always_comb begin
    ctrl_nxt      = ctrl_r;
    prdata_nxt    = prdata_r;
    senseEdge_nxt = senseEdge_r;
    // the strap is sampled only while reset is held
    if (rst) begin
      senseEdge_nxt = powerInputSenseSelect;
    end
    if (wrStrobe && pstrb[0] && paddr == pwr_ctrl_pkg::CTRL_OFS) begin
      ctrl_nxt = pwdata[5:0];
    end
    // read data is latched in the setup cycle, so no wait state
    if (psel && !penable && !pwrite) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        pwr_ctrl_pkg::CTRL_OFS: begin
          prdata_nxt[5:0] = ctrl_r;
        end
        pwr_ctrl_pkg::STATUS_OFS: begin
          prdata_nxt[pwr_ctrl_pkg::STAT_STATE_LSB +: 2] = state_r;
          prdata_nxt[pwr_ctrl_pkg::STAT_SYNC_BIT]  = onSync;
          prdata_nxt[pwr_ctrl_pkg::STAT_DEB_BIT]   = onLevel;
          prdata_nxt[pwr_ctrl_pkg::STAT_REQ_BIT]   = stbyReq;
          prdata_nxt[pwr_ctrl_pkg::STAT_SENSE_BIT] = senseEdge_r;
        end
        pwr_ctrl_pkg::INT_OFS: begin
          prdata_nxt[pwr_ctrl_pkg::INT_PON_BIT] = irq_r;
        end
        default: begin
          prdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_r   <= pwr_ctrl_pkg::CTRL_RST;
      prdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
    senseEdge_r <= senseEdge_nxt;
  end

  assign prdata = prdata_r;

  // ---------------- standby request ----------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      stbyMeta_r <= 1'b0;
      stbySync_r <= 1'b0;
    end else begin
      stbyMeta_r <= standbyPin;
      stbySync_r <= stbyMeta_r;
    end
  end

  assign stbyReq = stbySync_r ^
    ctrl_r[pwr_ctrl_pkg::CTRL_INV_BIT];
  assign holdCycles = holdOff(ctrl_r[pwr_ctrl_pkg::CTRL_HOLD_LSB +: 2]);

  // hold-off applies to entry and exit alike; a request that flips back
  // before the count runs out is dropped without effect
  always_comb begin
    stbyApplied_nxt = stbyApplied_r;
    holdCnt_nxt     = '0;
    if (stbyReq != stbyApplied_r) begin
      if (holdCnt_r >= holdCycles) begin
        stbyApplied_nxt = stbyReq;
      end else begin
        holdCnt_nxt = holdCnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stbyApplied_r <= 1'b0;
      holdCnt_r     <= '0;
    end else begin
      stbyApplied_r <= stbyApplied_nxt;
      holdCnt_r     <= holdCnt_nxt;
    end
  end

  // ---------------- power state ----------------
  assign isOff    = state_r == pwr_ctrl_pkg::ST_OFF;
  assign isAsleep = isOff || state_r == pwr_ctrl_pkg::ST_SLEEP;
  assign isAwake  = state_r == pwr_ctrl_pkg::ST_RUN ||
                    state_r == pwr_ctrl_pkg::ST_STANDBY;
  assign offTarget = sleepOnTurnOff ? pwr_ctrl_pkg::ST_SLEEP :
                                      pwr_ctrl_pkg::ST_OFF;

  always_comb begin
    longCnt_nxt  = '0;
    longDone_nxt = 1'b0;
    longFire     = 1'b0;
    // low time is timed on the synchronised pin, fires once per press
    if (!onSync) begin
      longDone_nxt = longDone_r;
      longCnt_nxt  = longCnt_r;
      if (!longDone_r) begin
        if (longCnt_r >= CW'(LONG_PRESS) - CW'(1)) begin
          longDone_nxt = 1'b1;
          longFire     = 1'b1;
        end else begin
          longCnt_nxt = longCnt_r + CW'(1);
        end
      end
    end
  end

  // level resets high; a pin held low at reset must not blip on
  always_comb begin
    settle_nxt  = settle_r;
    levelOk_nxt = levelOk_r;
    if (settle_r != 2'h3) begin
      settle_nxt = settle_r + 2'h1;
    end else if (onSync == onLevel) begin
      levelOk_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      settle_r  <= 2'h0;
      levelOk_r <= 1'b0;
    end else begin
      settle_r  <= settle_nxt;
      levelOk_r <= levelOk_nxt;
    end
  end

  always_comb begin
    state_nxt = state_r;
    if (!senseEdge_r) begin
      if (onLevel && isAsleep && levelOk_r) begin
        state_nxt = pwr_ctrl_pkg::ST_RUN;
      end else if (!onLevel && isAwake) begin
        state_nxt = offTarget;
      end else if (state_r == pwr_ctrl_pkg::ST_RUN && stbyApplied_r) begin
        state_nxt = pwr_ctrl_pkg::ST_STANDBY;
      end else if (state_r == pwr_ctrl_pkg::ST_STANDBY &&
                   !stbyApplied_r) begin
        state_nxt = pwr_ctrl_pkg::ST_RUN;
      end
    end else begin
      if (onFell && isAsleep) begin
        state_nxt = pwr_ctrl_pkg::ST_RUN;
      end else if (longFire && isAwake &&
                   ctrl_r[pwr_ctrl_pkg::CTRL_LPOE_BIT]) begin
        state_nxt = offTarget;
      end else if (state_r == pwr_ctrl_pkg::ST_RUN && stbyApplied_r) begin
        state_nxt = pwr_ctrl_pkg::ST_STANDBY;
      end else if (state_r == pwr_ctrl_pkg::ST_STANDBY &&
                   !stbyApplied_r) begin
        state_nxt = pwr_ctrl_pkg::ST_RUN;
      end
    end
  end

  // set beats clear, so an edge in the clearing cycle is kept
  always_comb begin
    irq_nxt = irq_r;
    if (isOff) begin
      irq_nxt = 1'b0;
    end
    if (wrStrobe && pstrb[0] && paddr == pwr_ctrl_pkg::INT_OFS &&
        pwdata[pwr_ctrl_pkg::INT_PON_BIT]) begin
      irq_nxt = 1'b0;
    end
    if (senseEdge_r && (onFell || onRose)) begin
      irq_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r    <= pwr_ctrl_pkg::ST_OFF;
      irq_r      <= 1'b0;
      longCnt_r  <= '0;
      longDone_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      irq_r      <= irq_nxt;
      longCnt_r  <= longCnt_nxt;
      longDone_r <= longDone_nxt;
    end
  end

  assign powerState    = state_r;
  assign standbyActive = state_r == pwr_ctrl_pkg::ST_STANDBY;
  assign powerOnIrq    = irq_r;

endmodule
`default_nettype wire

/* include/pwr_ctrl_pkg.sv */
// constants, register map and state type for the power input control block
package pwr_ctrl_pkg;

  // clock and timing
  localparam int CLK_MHZ        = 125;
  localparam int DBNC_SHORT_US  = 31250;
  localparam int DBNC_MID_US    = 125000;
  localparam int DBNC_LONG_US   = 750000;
  localparam int LONG_PRESS_MS  = 4000;
  localparam int HOLD_SHORT_US  = 1000;
  localparam int HOLD_MID_US    = 2000;
  localparam int HOLD_LONG_US   = 4000;

  localparam int DBNC_SHORT_CYC = DBNC_SHORT_US * CLK_MHZ;
  localparam int DBNC_MID_CYC   = DBNC_MID_US * CLK_MHZ;
  localparam int DBNC_LONG_CYC  = DBNC_LONG_US * CLK_MHZ;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * 1000 * CLK_MHZ;
  localparam int HOLD_SHORT_CYC = HOLD_SHORT_US * CLK_MHZ;
  localparam int HOLD_MID_CYC   = HOLD_MID_US * CLK_MHZ;
  localparam int HOLD_LONG_CYC  = HOLD_LONG_US * CLK_MHZ;

  // counter width, wide enough for the long press count
  localparam int CNT_W          = 30;

  // register map
  localparam int ADDR_W         = 12;
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] INT_OFS    = 12'h008;

  // control fields
  localparam int CTRL_LPOE_BIT  = 0;
  localparam int CTRL_DBNC_LSB  = 1;
  localparam int CTRL_INV_BIT   = 3;
  localparam int CTRL_HOLD_LSB  = 4;
  localparam int CTRL_W         = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SYNC_BIT  = 2;
  localparam int STAT_DEB_BIT   = 3;
  localparam int STAT_REQ_BIT   = 4;
  localparam int STAT_SENSE_BIT = 5;

  // interrupt field
  localparam int INT_PON_BIT    = 0;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_STANDBY,
    ST_SLEEP
  } pwr_state_e;

endpackage

/* logic/pwr_input_qualifier.sv */
// synchroniser and edge debouncer for the power-on pin
`timescale 1ns/1ns
`default_nettype none
module pwr_input_qualifier #(
  parameter int CW = 30
) (
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          pinAsync,
  input  wire logic [CW-1:0] fallCycles,
  input  wire logic [CW-1:0] riseCycles,
  output logic               syncLevel,
  output logic               level,
  output logic               rosePulse,
  output logic               fellPulse
);

  logic          meta_r;
  logic          sync_r;
  logic          deb_r;
  logic          deb_nxt;
  logic          rose_r;
  logic          rose_nxt;
  logic          fell_r;
  logic          fell_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] limit;

  // pin idles high: a released button must not look like a press
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= pinAsync;
      sync_r <= meta_r;
    end
  end

  always_comb begin
    deb_nxt  = deb_r;
    rose_nxt = 1'b0;
    fell_nxt = 1'b0;
    cnt_nxt  = '0;
    limit    = sync_r ? riseCycles : fallCycles;
    if (sync_r != deb_r) begin
      // a glitch shorter than the window restarts the count
      if (cnt_r >= limit - CW'(1)) begin
        deb_nxt  = sync_r;
        rose_nxt = sync_r;
        fell_nxt = ~sync_r;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      deb_r  <= 1'b1;
      rose_r <= 1'b0;
      fell_r <= 1'b0;
      cnt_r  <= '0;
    end else begin
      deb_r  <= deb_nxt;
      rose_r <= rose_nxt;
      fell_r <= fell_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign syncLevel = sync_r;
  assign level     = deb_r;
  assign rosePulse = rose_r;
  assign fellPulse = fell_r;

endmodule
`default_nettype wire

/* tb/pwr_ctrl_chk.sv */
// port checker for the power input control block
`timescale 1ns/1ns
`default_nettype none
module pwr_ctrl_chk (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        powerInputSenseSelect,
  input wire logic        sleepOnTurnOff,
  input wire logic [1:0]  powerState,
  input wire logic        standbyActive,
  input wire logic        powerOnIrq
);
  logic acc;
  logic clrWr;
  assign acc = psel && penable;
  assign clrWr = acc && pwrite && paddr == 12'h008;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence sWake;
    powerState inside {2'h0, 2'h3} ##1 !(powerState inside {2'h0, 2'h3});
  endsequence
  sequence sOff;
    powerState inside {2'h1, 2'h2} ##1 powerState inside {2'h0, 2'h3};
  endsequence
  chk_wake_to_run: assert property (sWake |-> powerState == 2'h1)
    else $error("wake not into run");
  chk_off_target: assert property (sOff |->
    powerState == ($past(sleepOnTurnOff) ? 2'h3 : 2'h0))
    else $error("wrong turn-off target");
  chk_stby_decode: assert property (
    standbyActive == (powerState == 2'h2)) else $error("standby flag");
  chk_stby_entry: assert property (
    $rose(standbyActive) |-> $past(powerState) == 2'h1)
    else $error("standby entered from wrong state");
  chk_irq_edge: assert property (
    $rose(powerOnIrq) |-> powerInputSenseSelect) else $error("level irq");
  chk_irq_sticky: assert property (
    $fell(powerOnIrq) |-> $past(powerState) == 2'h0 || $past(clrWr))
    else $error("irq dropped on its own");
  chk_off_clears: assert property (
    powerOnIrq && powerState == 2'h0 |=> !powerOnIrq || powerState == 2'h1)
    else $error("irq kept in off");
  chk_err_unmapped: assert property (
    acc && !(paddr inside {12'h000, 12'h004, 12'h008}) |->
    pslverr && pready && (pwrite || prdata == 32'h0)) else $error("no error");
endmodule
bind pmic_power_control_inputs pwr_ctrl_chk chk_u (
  .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .powerInputSenseSelect(powerInputSenseSelect),
  .sleepOnTurnOff(sleepOnTurnOff), .powerState(powerState),
  .standbyActive(standbyActive), .powerOnIrq(powerOnIrq));
`default_nettype wire

/* tb/pwr_button_model.sv */
// push-button and standby line driven by the host side
`timescale 1ns/1ns
`default_nettype none
module pwr_button_model (
  input  wire logic mclk,
  input  wire logic pressed,
  input  wire logic stbyLevel,
  output logic      powerOnPin,
  output logic      standbyPin
);
  // pull-up keeps the released button line high
  initial powerOnPin = 1'b1;
  initial standbyPin = 1'b0;
  always @(posedge mclk) begin
    powerOnPin <= !pressed;
    standbyPin <= stbyLevel;
  end
endmodule
`default_nettype wire

/* tb/pmic_power_control_inputs_test.sv */
// self-checking bench for the power input control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module pmic_power_control_inputs_test;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pinOn;
  logic        pinStby;
  logic        sense = 1'b0;
  logic        sleepSel = 1'b0;
  logic [1:0]  state;
  logic        irq;
  logic        pressed = 1'b0;
  logic        stbyLevel = 1'b0;
  logic [31:0] q;
  logic        e;
  logic [3:0]  strb = 4'hf;
  logic        stby;
  int          fail_count = 0;
  int          samples_checked = 0;
  localparam int DB_SHORT  = 8;
  localparam int DB_MID    = 16;
  localparam int DB_LONG   = 32;
  localparam int PRESS_LEN = 100;
  localparam int HO_SHORT  = 4;
  localparam int HO_MID    = 8;
  localparam int HO_LONG   = 12;
  always #4 mclk = ~mclk;
  pwr_button_model btn_u (.mclk(mclk), .pressed(pressed),
    .stbyLevel(stbyLevel), .powerOnPin(pinOn), .standbyPin(pinStby));
  // short counts keep the run brief; expectations use the same values
  pmic_power_control_inputs #(.DBNC_SHORT(DB_SHORT), .DBNC_MID(DB_MID),
    .DBNC_LONG(DB_LONG), .LONG_PRESS(PRESS_LEN), .HOLD_SHORT(HO_SHORT),
    .HOLD_MID(HO_MID), .HOLD_LONG(HO_LONG)) dut_u (
    .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerOnPin(pinOn),
    .standbyPin(pinStby), .powerInputSenseSelect(sense),
    .sleepOnTurnOff(sleepSel), .powerState(state), .standbyActive(stby),
    .powerOnIrq(irq));
  task automatic stop_test();
    $display("checks %0d fails %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d);
    int i;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (i == 16) begin
      fail_count++;
      $display("[FAIL] pready exp 1 got 0");
      stop_test();
    end
  endtask
  // waits for {irq, state} under mask; too early counts as wrong
  task automatic expectAt(input logic [2:0] x, input logic [2:0] m,
                          input int lo, input int hi);
    int i;
    for (i = 0; i < hi; i++) begin
      @(posedge mclk);
      if (({irq, state} & m) === x) break;
    end
    `CHK("cycles to event", 1'b1, i >= lo && i < hi)
    if (i >= hi) begin
      stop_test();
    end
  endtask
  task automatic doReset(input logic s);
    @(posedge mclk);
    sense <= s;
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic t_regs();
    doReset(1'b1);
    apb(12'h000, 1'b0, 32'h0);
    `CHK("ctrl reset", 32'h0, q)
    apb(12'h000, 1'b1, 32'hffff_ffff);
    apb(12'h000, 1'b0, 32'h0);
    `CHK("ctrl fields", 32'h3f, q)
    strb <= 4'he;
    apb(12'h000, 1'b1, 32'h0);
    strb <= 4'hf;
    apb(12'h00c, 1'b1, 32'h0);
    `CHK("unmapped wr err", 1'b1, e)
    apb(12'h000, 1'b0, 32'h0);
    `CHK("masked writes", 32'h3f, q)
    apb(12'h00c, 1'b0, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    $display("done regs");
  endtask
  task automatic t_level();
    doReset(1'b0);
    expectAt(3'b001, 3'b011, 0, 24);
    pressed <= 1'b1;
    expectAt(3'b000, 3'b011, 8, 16);
    sleepSel <= 1'b1;
    pressed <= 1'b0;
    expectAt(3'b001, 3'b011, 8, 16);
    pressed <= 1'b1;
    expectAt(3'b011, 3'b011, 8, 16);
    `CHK("level irq", 1'b0, irq)
    pressed <= 1'b0;
    sleepSel <= 1'b0;
    $display("done level");
  endtask
  task automatic t_edge();
    doReset(1'b1);
    repeat (20) @(posedge mclk);
    `CHK("edge idle", 2'h0, state)
    pressed <= 1'b1;
    expectAt(3'b101, 3'b111, 8, 16);
    apb(12'h008, 1'b1, 32'h1);
    apb(12'h008, 1'b0, 32'h0);
    `CHK("irq clear", 32'h0, q)
    pressed <= 1'b0;
    expectAt(3'b100, 3'b100, 8, 16);
    apb(12'h008, 1'b1, 32'h1);
    pressed <= 1'b1;
    expectAt(3'b100, 3'b100, 8, 16);
    repeat (120) @(posedge mclk);
    `CHK("no long press", 2'h1, state)
    pressed <= 1'b0;
    repeat (16) @(posedge mclk);
    apb(12'h000, 1'b1, 32'h1);
    pressed <= 1'b1;
    expectAt(3'b000, 3'b011, 95, 112);
    expectAt(3'b000, 3'b100, 0, 4);
    pressed <= 1'b0;
    sleepSel <= 1'b1;
    repeat (16) @(posedge mclk);
    pressed <= 1'b1;
    expectAt(3'b011, 3'b011, 95, 112);
    pressed <= 1'b0;
    repeat (16) @(posedge mclk);
    pressed <= 1'b1;
    expectAt(3'b001, 3'b011, 8, 16);
    pressed <= 1'b0;
    sleepSel <= 1'b0;
    $display("done edge");
  endtask
  task automatic t_dbnc();
    int n[4] = '{DB_SHORT, DB_SHORT, DB_MID, DB_LONG};
    for (int c = 0; c < 4; c++) begin
      doReset(1'b1);
      apb(12'h000, 1'b1, 32'(c) << 1);
      pressed <= 1'b1;
      expectAt(3'b001, 3'b011, n[c], n[c] + 8);
      apb(12'h008, 1'b1, 32'h1);
      pressed <= 1'b0;
      expectAt(3'b100, 3'b100, 8, 16);
    end
    $display("done debounce");
  endtask
  task automatic t_stby();
    int h[4] = '{0, HO_SHORT, HO_MID, HO_LONG};
    doReset(1'b0);
    expectAt(3'b001, 3'b011, 0, 24);
    for (int c = 0; c < 4; c++) begin
      // long hold-off masks the brief request while invert changes
      apb(12'h000, 1'b1, {26'h0, 2'b11, stbyLevel, 3'b000});
      stbyLevel <= c[0];
      apb(12'h000, 1'b1, {26'h0, 2'(c), c[0], 3'b000});
      stbyLevel <= !c[0];
      expectAt(3'b010, 3'b011, h[c], h[c] + 8);
      apb(12'h004, 1'b0, 32'h0);
      `CHK("standby request", 1'b1, q[4])
      `CHK("standby flag", 1'b1, stby)
      stbyLevel <= c[0];
      expectAt(3'b001, 3'b011, h[c], h[c] + 8);
    end
    $display("done standby");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_level();
    t_edge();
    t_dbnc();
    t_stby();
    stop_test();
  end
endmodule
`default_nettype wire
